// *** include/adc_link_pkg.sv ***
package adc_link_pkg;
   // Result word layout
   localparam int WORD_BITS = 24;
   localparam int DATA_BITS = 22;
   localparam int BIT_CNT_W = 5;
   localparam int OVER_HIGH_POS = 23;
   localparam int OVER_LOW_POS = 22;
   // System clock
   localparam longint CLK_FREQ_HZ = 200_000_000;
   localparam int CLK_FREQ_MHZ = 200;
   // Serial clock ceiling and least half period (rounded up)
   localparam int SCK_MAX_FREQ_HZ = 5_000_000;
   localparam int SCK_HALF_CYCLES_DEF =
      int'((CLK_FREQ_HZ + 2 * SCK_MAX_FREQ_HZ - 1) / (2 * SCK_MAX_FREQ_HZ));
   // Chip select least low and least high times
   localparam int CS_LOW_MIN_NS = 50;
   localparam int CS_LOW_CYCLES = (CS_LOW_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int CS_DISABLE_NS = 90;
   localparam int CS_HIGH_CYCLES = (CS_DISABLE_NS * CLK_FREQ_MHZ + 999) / 1000;
   // Conversion time and wake-up extension after shutdown
   localparam int CONV_TIME_US = 80000;
   localparam int CONV_CYCLES_DEF = CONV_TIME_US * CLK_FREQ_MHZ;
   localparam longint OSC_FREQ_HZ = 102400;
   localparam longint WAKE_OSC_PERIODS = 144;
   localparam int WAKE_CYCLES_DEF = int'((WAKE_OSC_PERIODS * CLK_FREQ_HZ) / OSC_FREQ_HZ);
   localparam int CONV_CNT_W = 25;
   // Synchroniser reset level: chip select and clock seen high
   localparam logic [2:0] SYNC_RESET_HIGH = 3'h7;

   typedef enum logic [1:0] {
      DEV_SHUTDOWN = 2'b00,
      DEV_CONVERT = 2'b01,
      DEV_READY = 2'b10,
      DEV_SHIFT = 2'b11
   } dev_state_type;

   typedef enum logic [2:0] {
      HOST_IDLE = 3'b000,
      HOST_PULSE = 3'b001,
      HOST_GAP = 3'b010,
      HOST_WAIT = 3'b011,
      HOST_FALL = 3'b100,
      HOST_RISE = 3'b101,
      HOST_END = 3'b110
   } host_state_type;
endpackage

// *** include/adc_link_if.sv ***
`timescale 1ns/100ps
interface adc_link_if;
   logic cs_n;
   logic sck;
   logic sdo_o;
   logic sdo_oe;
   logic data_ready_output;

   // Shared line with pull-up: released reads high
   assign data_ready_output = sdo_oe ? sdo_o : 1'b1;

   modport dev (input cs_n, input sck, output sdo_o, output sdo_oe);
   modport host (output cs_n, output sck, input data_ready_output);
endinterface

// *** design/adc_conv_device.sv ***
`timescale 1ns/100ps
// Function
// - Works with clock modes 1,1 and 0,0
// - Output bit changes on serial clock fall
// - Link inputs sampled every system clock cycle
// - Serial clock may idle either level
// - Finished conversion drives data line low
// - Falls then give 24-bit result word
// - Chip select gates all serial traffic
// - Chip select fall in shutdown starts a conversion
// - Early chip select rise means single conversion
// - Chip select held low converts continuously
// - Chip select tied low: two-wire continuous
// - Data line released while chip select high
// - Chip select low at power-up auto-converts
// - Host serial clock at most 5 MHz
// - Result state cleared between conversions
// - Device enters shutdown by itself after a single-conversion or aborted read
// - Calibrated first result, no settling delay
// - Result is 22-bit two's complement
// - Two flags: high and low overrange
module adc_conv_device #(
   parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES_DEF,
   parameter int WAKE_CYCLES = adc_link_pkg::WAKE_CYCLES_DEF,
   parameter int CNT_W = adc_link_pkg::CONV_CNT_W
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   adc_link_if.dev link,
   input wire logic [adc_link_pkg::DATA_BITS-1:0] sample_code,
   input wire logic sample_over_high,
   input wire logic sample_over_low,
   output logic conv_done,
   output logic shutdown,
   output logic continuous_mode
);
   import adc_link_pkg::*;

   typedef struct packed {
      logic [2:0] cs_sync;
      logic [2:0] sck_sync;
      dev_state_type state;
      logic [CNT_W-1:0] cnt;
      logic [WORD_BITS-1:0] word;
      logic [BIT_CNT_W-1:0] bits;
      logic sdo;
      logic single;
      logic done;
   } dev_reg_type;

   dev_reg_type q;
   dev_reg_type d;
   logic cs_low;
   logic cs_fall;
   logic sck_fall;
   logic sck_rise;

   // Enter conversion with cleared result state; wake adds the start-up time
   function automatic dev_reg_type begin_conv(input dev_reg_type r, input logic wake);
      dev_reg_type n;
      n = r;
      n.state = DEV_CONVERT;
      n.cnt = wake ? CNT_W'(CONV_CYCLES + WAKE_CYCLES) : CNT_W'(CONV_CYCLES);
      n.word = '0;
      n.bits = '0;
      n.sdo = 1'b1;
      n.single = 1'b0;
      return n;
   endfunction

   // Fall across the two older stages of a synchroniser
   function automatic logic fell_edge(input logic [2:0] s);
      return s[2] & ~s[1];
   endfunction

   // Rise across the two older stages of a synchroniser
   function automatic logic rose_edge(input logic [2:0] s);
      return ~s[2] & s[1];
   endfunction

   // Result word: overload flags above the calibrated code
   function automatic logic [WORD_BITS-1:0] pack_result(
      input logic over_high,
      input logic over_low,
      input logic [DATA_BITS-1:0] code
   );
      logic [WORD_BITS-1:0] w;
      w = '0;
      w[OVER_HIGH_POS] = over_high;
      w[OVER_LOW_POS] = over_low;
      w[DATA_BITS-1:0] = code;
      return w;
   endfunction

   // Next bit onto the line, MSB first, and count it
   function automatic dev_reg_type shift_out(
      input dev_reg_type r,
      input logic [BIT_CNT_W-1:0] n
   );
      dev_reg_type s;
      s = r;
      s.sdo = r.word[WORD_BITS-1];
      s.word = {r.word[WORD_BITS-2:0], 1'b0};
      s.bits = n;
      return s;
   endfunction

   // Drop any held word and power down
   function automatic dev_reg_type power_down(input dev_reg_type r);
      dev_reg_type s;
      s = r;
      s.state = DEV_SHUTDOWN;
      s.word = '0;
      s.sdo = 1'b1;
      return s;
   endfunction

   // Edges of the synchronised link inputs; stage 0 feeds only stage 1
   always_comb begin
      cs_low = ~q.cs_sync[1];
      cs_fall = fell_edge(q.cs_sync);
      sck_fall = fell_edge(q.sck_sync);
      sck_rise = rose_edge(q.sck_sync);
   end

   // Next state of the whole device
   always_comb begin
      d = q;
      d.done = 1'b0;
      // Link inputs shift into their synchronisers every cycle
      d.cs_sync = {q.cs_sync[1:0], link.cs_n};
      d.sck_sync = {q.sck_sync[1:0], link.sck};
      unique case (q.state)
         // Idle: line high, wait for a select fall
         DEV_SHUTDOWN: begin
            d.sdo = 1'b1;
            // Synchroniser resets high, so a tied-low select also falls
            if (cs_fall) begin
               d = begin_conv(d, 1'b1);
            end
         end
         // Converting: count down, then latch the word and flag ready
         DEV_CONVERT: begin
            if (!cs_low) begin
               d.single = 1'b1;
            end
            if (q.cnt == '0) begin
               // Calibrated result latched whole at the end of the count
               d.word = pack_result(sample_over_high, sample_over_low, sample_code);
               d.state = DEV_READY;
               d.sdo = 1'b0;
               d.done = 1'b1;
            end else begin
               d.cnt = q.cnt - 1'b1;
            end
         end
         // Ready low stands until the first selected fall
         DEV_READY: begin
            d.sdo = 1'b0;
            if (cs_low && sck_fall) begin
               d = shift_out(d, BIT_CNT_W'(1));
               d.state = DEV_SHIFT;
            end
         end
         // Shifting: one bit per fall, word ends at the following rise
         DEV_SHIFT: begin
            if (!cs_low) begin
               // Read aborted: drop the word and power down
               d = power_down(d);
            end else if (sck_fall && q.bits != BIT_CNT_W'(WORD_BITS)) begin
               d = shift_out(d, q.bits + 1'b1);
            end else if (sck_rise && q.bits == BIT_CNT_W'(WORD_BITS)) begin
               // Last bit taken by the host
               if (q.single) begin
                  d = power_down(d);
               end else begin
                  d = begin_conv(d, 1'b0);
               end
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         // Synchronisers start at the deselected, clock-high level
         q.cs_sync <= SYNC_RESET_HIGH;
         q.sck_sync <= SYNC_RESET_HIGH;
         q.state <= DEV_SHUTDOWN;
         q.cnt <= '0;
         q.word <= '0;
         q.bits <= '0;
         q.sdo <= 1'b1;
         q.single <= 1'b0;
         q.done <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // Line driven only while selected
   assign link.sdo_o = q.sdo;
   assign link.sdo_oe = ~q.cs_sync[1];
   // Status outputs
   assign conv_done = q.done;
   assign shutdown = (q.state == DEV_SHUTDOWN);
   assign continuous_mode = ~q.single;
endmodule

// *** design/adc_conv_host.sv ***
`timescale 1ns/100ps
module adc_conv_host #(
   parameter logic CPOL = 1'b0,
   parameter int HALF_CYCLES = adc_link_pkg::SCK_HALF_CYCLES_DEF,
   parameter int GAP_CYCLES = adc_link_pkg::CS_HIGH_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   adc_link_if.host link,
   input wire logic start_req,
   input wire logic continuous_req,
   output logic [adc_link_pkg::WORD_BITS-1:0] result_word,
   output logic result_valid,
   output logic busy
);
   import adc_link_pkg::*;

   localparam int TW = 16;

   typedef struct packed {
      host_state_type state;
      logic [TW-1:0] cnt;
      logic [BIT_CNT_W-1:0] bits;
      logic [WORD_BITS-1:0] shift;
      logic [WORD_BITS-1:0] result;
      logic valid;
      logic cs_n;
      logic sck;
      logic cont;
      logic [1:0] line_sync;
   } host_reg_type;

   host_reg_type q;
   host_reg_type d;
   logic tick;

   // Divider: enable held while the phase count is zero, until a state reloads it
   assign tick = (q.cnt == '0);

   // Next state of the host sequencer
   always_comb begin
      d = q;
      d.valid = 1'b0;
      d.line_sync = {q.line_sync[0], link.data_ready_output};
      if (!tick) begin
         d.cnt = q.cnt - 1'b1;
      end
      unique case (q.state)
         HOST_IDLE: begin
            d.cs_n = 1'b1;
            d.sck = CPOL;
            if (tick && start_req) begin
               d.cont = continuous_req;
               d.cs_n = 1'b0;
               d.cnt = continuous_req ? TW'(HALF_CYCLES) : TW'(CS_LOW_CYCLES);
               d.state = continuous_req ? HOST_WAIT : HOST_PULSE;
            end
         end
         HOST_PULSE: begin
            if (tick) begin
               d.cs_n = 1'b1;
               d.cnt = TW'(GAP_CYCLES);
               d.state = HOST_GAP;
            end
         end
         HOST_GAP: begin
            if (tick) begin
               d.cs_n = 1'b0;
               d.cnt = TW'(HALF_CYCLES);
               d.state = HOST_WAIT;
            end
         end
         HOST_WAIT: begin
            if (tick && !q.line_sync[1]) begin
               d.sck = 1'b1; // Mode 0,0 leads with a rise the device ignores
               d.cnt = TW'(HALF_CYCLES);
               d.bits = '0;
               d.state = HOST_FALL;
            end
         end
         HOST_FALL: begin
            if (tick) begin
               d.sck = 1'b0;
               d.cnt = TW'(HALF_CYCLES);
               d.state = HOST_RISE;
            end
         end
         HOST_RISE: begin
            if (tick) begin
               d.sck = 1'b1;
               d.shift = {q.shift[WORD_BITS-2:0], q.line_sync[1]};
               d.bits = q.bits + 1'b1;
               d.cnt = TW'(HALF_CYCLES);
               d.state = (q.bits == BIT_CNT_W'(WORD_BITS - 1)) ? HOST_END : HOST_FALL;
            end
         end
         HOST_END: begin
            if (tick) begin
               d.result = q.shift;
               d.valid = 1'b1;
               d.sck = CPOL;
               d.cnt = TW'(HALF_CYCLES);
               if (q.cont && continuous_req) begin
                  d.state = HOST_WAIT;
               end else begin
                  d.cs_n = 1'b1;
                  d.cnt = TW'(GAP_CYCLES);
                  d.state = HOST_IDLE;
               end
            end
         end
         default: begin
            d.state = HOST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q.state <= HOST_IDLE;
         q.cnt <= '0;
         q.bits <= '0;
         q.shift <= '0;
         q.result <= '0;
         q.valid <= 1'b0;
         q.cs_n <= 1'b1;
         q.sck <= CPOL;
         q.cont <= 1'b0;
         q.line_sync <= 2'h3;
      end else begin
         q <= d;
      end
   end

   assign link.cs_n = q.cs_n;
   assign link.sck = q.sck;
   assign result_word = q.result;
   assign result_valid = q.valid;
   assign busy = (q.state != HOST_IDLE);
endmodule

// *** tb/adc_conv_asserts.sv ***
`timescale 1ns/100ps
module adc_conv_asserts #(
   parameter int CONV_CYCLES = 200,
   parameter int WAKE_CYCLES = 50
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic data_ready_output
);
   localparam int FIRST_MIN = CONV_CYCLES + WAKE_CYCLES - 40;
   localparam int FIRST_MAX = CONV_CYCLES + WAKE_CYCLES + 20;
   localparam int NEXT_MIN = CONV_CYCLES - 10;
   localparam int NEXT_MAX = CONV_CYCLES + 20;
   logic wait_q;
   logic restart_q;
   logic [4:0] fall_q;
   logic [9:0] since_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Falls of a word, wait for ready, restart flag
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fall_q <= '0;
         wait_q <= 1'b0;
         restart_q <= 1'b0;
      end else if (cs_n) begin
         fall_q <= '0;
         wait_q <= 1'b0;
         restart_q <= 1'b0;
      end else if ($fell(cs_n)) begin
         wait_q <= 1'b1;
      end else if (fall_q == 5'h18 && $rose(sck)) begin
         fall_q <= '0;
         wait_q <= 1'b1;
         restart_q <= 1'b1;
      end else if (wait_q && $fell(data_ready_output)) begin
         wait_q <= 1'b0;
         restart_q <= 1'b0;
      end else if (!wait_q && $fell(sck)) begin
         fall_q <= fall_q + 5'h01;
      end
   end
   // Cycles since the last word ended
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) since_q <= '0;
      else if (fall_q == 5'h18 && $rose(sck) && !cs_n) since_q <= '0;
      else if (since_q != 10'h3ff) since_q <= since_q + 10'h001;
   end
   sequence s_word_end;
      fall_q == 5'h18 && $rose(sck) && !cs_n;
   endsequence
   sequence s_ready;
      wait_q && $fell(data_ready_output);
   endsequence
   property p_release;
      cs_n [*5] |-> !sdo_oe;
   endproperty
   a_release: assert property (p_release) else $error("line kept");
   property p_quick_release;
      $rose(cs_n) |-> ##[2:5] !sdo_oe;
   endproperty
   a_quick_release: assert property (p_quick_release) else $error("slow release");
   property p_select;
      !cs_n [*6] |-> sdo_oe;
   endproperty
   a_select: assert property (p_select) else $error("line not driven");
   property p_stable;
      (sck && sdo_oe) [*5] |-> $stable(sdo_o);
   endproperty
   a_stable: assert property (p_stable) else $error("bit moved, clock high");
   property p_first;
      $fell(cs_n) |-> ##[FIRST_MIN:FIRST_MAX] s_ready;
   endproperty
   a_first: assert property (p_first) else $error("ready late");
   property p_restart;
      s_ready ##0 restart_q |-> since_q >= NEXT_MIN && since_q <= NEXT_MAX;
   endproperty
   a_restart: assert property (p_restart) else $error("restart time");
   property p_ready_hold;
      s_ready |-> !data_ready_output [*8];
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready lost");
   property p_word_end;
      s_word_end |-> ##[3:4] data_ready_output;
   endproperty
   a_word_end: assert property (p_word_end) else $error("line low after word");
endmodule

// *** tb/adc_serial_conversion_control_tb_top.sv ***
`timescale 1ns/100ps
module adc_serial_conversion_control_tb_top;
   import adc_link_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic start_req = 1'b0;
   logic continuous_req = 1'b0;
   logic over_high = 1'b0;
   logic over_low = 1'b0;
   logic [DATA_BITS-1:0] code = '0;
   logic [WORD_BITS-1:0] result_word;
   logic [WORD_BITS-1:0] got;
   logic result_valid;
   logic busy;
   logic conv_done;
   logic shutdown;
   logic continuous_mode;
   logic continuous_mode_b;
   int err_count = 0;
   int compares = 0;
   int done_cnt = 0;
   logic [WORD_BITS-1:0] words [5] = '{24'h955555, 24'h600000, 24'h0aaaab, 24'h3fffff, 24'h1ffffe};
   adc_link_if link ();
   adc_link_if link_b ();
   // Device facing the host, host in mode 0,0 at 5 MHz
   adc_conv_device #(.CONV_CYCLES(200), .WAKE_CYCLES(50)) i_adc_conv_device (
      .clk_sys(clk_sys), .reset_n(reset_n), .link(link.dev), .sample_code(code),
      .sample_over_high(over_high), .sample_over_low(over_low), .conv_done(conv_done),
      .shutdown(shutdown), .continuous_mode(continuous_mode));
   adc_conv_host i_adc_conv_host (
      .clk_sys(clk_sys), .reset_n(reset_n), .link(link.host), .start_req(start_req),
      .continuous_req(continuous_req), .result_word(result_word),
      .result_valid(result_valid), .busy(busy));
   // Second device, select tied low, clocked by the bench in mode 1,1
   adc_conv_device #(.CONV_CYCLES(200), .WAKE_CYCLES(50)) i_adc_conv_device_b (
      .clk_sys(clk_sys), .reset_n(reset_n), .link(link_b.dev), .sample_code(code),
      .sample_over_high(over_high), .sample_over_low(over_low), .conv_done(),
      .shutdown(), .continuous_mode(continuous_mode_b));
   adc_conv_asserts i_adc_conv_asserts (
      .clk_sys(clk_sys), .reset_n(reset_n), .cs_n(link.cs_n), .sck(link.sck),
      .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .data_ready_output(link.data_ready_output));
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Finished conversions of the first device
   always @(negedge clk_sys) begin
      if (conv_done === 1'b1) done_cnt <= done_cnt + 1;
   end
   task results;
      if (err_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task check(input logic [WORD_BITS-1:0] act, input logic [WORD_BITS-1:0] exp);
      compares++;
      if (act !== exp) begin
         err_count++;
         $display("wrong value at %0t: %h, expected %h", $time, act, exp);
      end
   endtask
   task check_bit(input logic act, input logic exp);
      check({23'h0, act}, {23'h0, exp});
   endtask
   // Bounded wait: 0 busy, 1 result valid, 2 second line
   task wait_sig(input int sel, input logic v);
      int n;
      n = 0;
      while ((sel == 0 ? busy : sel == 1 ? result_valid : link_b.data_ready_output) !== v) begin
         @(negedge clk_sys);
         n++;
         if (n == 3000) begin
            err_count++;
            $display("wrong value at %0t: wait ran out", $time);
            results();
         end
      end
   endtask
   // Mode 0 single, 1 continuous, 2 continuous then stop
   task host_run(input logic [1:0] mode, input logic [WORD_BITS-1:0] w);
      {over_high, over_low, code} = w;
      continuous_req = (mode == 2'h1);
      start_req = 1'b1;
      @(negedge clk_sys);
      wait_sig(0, 1'b1);
      start_req = 1'b0;
      repeat (40) @(negedge clk_sys);
      check_bit(continuous_mode, mode != 2'h0);
      wait_sig(1, 1'b1);
      check(result_word, w);
      repeat (30) @(negedge clk_sys);
      if (mode != 2'h1) check_bit(link.sdo_oe, 1'b0);
      if (mode == 2'h0) check_bit(shutdown, 1'b1);
   endtask
   // Bench reads the second device, idle high, 5 MHz
   task read_b(input logic [WORD_BITS-1:0] w);
      wait_sig(2, 1'b0);
      for (int i = 23; i >= 0; i--) begin
         link_b.sck = 1'b0;
         repeat (20) @(negedge clk_sys);
         got[i] = link_b.data_ready_output;
         link_b.sck = 1'b1;
         repeat (20) @(negedge clk_sys);
      end
      check(got, w);
   endtask
   // Main sequence
   initial begin
      link_b.cs_n = 1'b0;
      link_b.sck = 1'b1;
      repeat (5) @(negedge clk_sys);
      reset_n = 1'b1;
      for (int i = 0; i < 3; i++) host_run(2'h0, words[i]);
      host_run(2'h1, words[3]);
      host_run(2'h2, words[4]);
      repeat (400) @(negedge clk_sys);
      check(WORD_BITS'(done_cnt), 24'h000006);
      read_b(words[0]);
      check_bit(continuous_mode_b, 1'b1);
      read_b(words[4]);
      results();
   end
endmodule
